//--- inc/sfe_map.vh
// constants and address layout of the serial flash front end
//==============================================================
`ifndef SFE_MAP_VH
`define SFE_MAP_VH
`define SFE_CMD_DUAL_READ 8'h3B
`define SFE_CMD_READ      8'h03
`define SFE_CMD_FAST_READ 8'h0B
`define SFE_ADDR_W        20
`define SFE_PAGE_LSB      8
`define SFE_SECT_LSB      12
`define SFE_B32_LSB       15
`define SFE_B64_LSB       16
`define SFE_ADDR_MSB      19
`define SFE_BIT_LAST      3'h7
`define SFE_ADDR_BYTES    2'h3
`define SFE_DUMMY_BYTES   2'h1
`endif

//--- design/sfe_addr_split.v
// address decomposition into page, sector and block numbers
`timescale 1ns/10ps
`default_nettype none
`include "sfe_map.vh"
module sfe_addr_split (
	input  wire [23:0] addr_i,      // byte address from the host
	output wire [19:0] array_addr_o, // address within the array
	output wire [7:0]  page_byte_o, // byte within page
	output wire [11:0] page_o,      // page number
	output wire [7:0]  sector_o,    // sector number
	output wire [4:0]  block32_o,   // 32 KB block number
	output wire [3:0]  block64_o    // 64 KB block number
);
	// upper address bits beyond the array wrap, only 20 bits decode
	assign array_addr_o = addr_i[`SFE_ADDR_MSB:0];
	assign page_byte_o  = addr_i[`SFE_PAGE_LSB-1:0];
	assign page_o       = addr_i[`SFE_ADDR_MSB:`SFE_PAGE_LSB];
	assign sector_o     = addr_i[`SFE_ADDR_MSB:`SFE_SECT_LSB];
	assign block32_o    = addr_i[`SFE_ADDR_MSB:`SFE_B32_LSB];
	assign block64_o    = addr_i[`SFE_ADDR_MSB:`SFE_B64_LSB];
endmodule
`default_nettype wire

//--- design/sfe_front_end.v
// spi target front end of the serial nor flash
`timescale 1ns/10ps
`default_nettype none
`include "sfe_map.vh"
module sfe_front_end (
	input  wire        sys_clk_i,      // 250 MHz system clock
	input  wire        reset_n_i,      // async reset, active low
	input  wire        sclk_i,         // serial clock pin
	input  wire        sel_n_i,        // chip select pin, active low
	input  wire        dual_line_zero_i, // line zero level (serial in)
	input  wire        dual_line_one_i,  // line one level (serial out)
	input  wire        wprot_n_i,      // write protect pin, active low
	input  wire [7:0]  rd_data_i,      // array byte at rd_addr_o
	output reg         dual_line_zero_o, // line zero drive value
	output reg         dual_line_zero_oe_n_o, // line zero enable, low drives
	output reg         dual_line_one_o,  // line one drive value
	output reg         dual_line_one_oe_n_o,  // line one enable, low drives
	output reg  [7:0]  cmd_o,          // last command byte
	output reg         cmd_vld_o,      // pulse, command byte taken
	output reg  [19:0] rd_addr_o,      // array address being read
	output reg  [7:0]  page_byte_o,    // byte within page of address
	output reg  [11:0] page_o,         // page of address
	output reg  [7:0]  sector_o,       // sector of address
	output reg  [4:0]  block32_o,      // 32 KB block of address
	output reg  [3:0]  block64_o,      // 64 KB block of address
	output reg         addr_vld_o,     // pulse, address complete
	output reg  [7:0]  wr_byte_o,      // data byte after the address
	output reg         wr_vld_o,       // pulse, data byte taken
	output reg         wprot_n_o       // synchronised write protect
);
//==============================================================
// pin synchronisers
	// every pin lags two clocks, so sclk high and low must each
	// last one system clock or an edge is lost
	reg [1:0] sclk_s_r, sel_s_r, d0_s_r, wp_s_r;
	reg       sclk_d_r;
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sclk_s_r <= 2'h0;
			sel_s_r  <= 2'h3;
			d0_s_r   <= 2'h0;
			wp_s_r   <= 2'h3;
			sclk_d_r <= 1'h0;
		end else begin
			sclk_s_r <= {sclk_s_r[0], sclk_i};
			sel_s_r  <= {sel_s_r[0], sel_n_i};
			d0_s_r   <= {d0_s_r[0], dual_line_zero_i};
			wp_s_r   <= {wp_s_r[0], wprot_n_i};
			sclk_d_r <= sclk_s_r[1];
		end
	end
	// select high parks the logic, so idle clock level is irrelevant
	wire selected = ~sel_s_r[1];
	wire rise = selected & sclk_s_r[1] & ~sclk_d_r;
	wire fall = selected & ~sclk_s_r[1] & sclk_d_r;
	wire sin  = d0_s_r[1];
//==============================================================
// address split
	// fields follow addr_r one cycle late, so every output stays a flop
	wire [19:0] a_arr;
	wire [7:0]  a_pb, a_sec;
	wire [11:0] a_pg;
	wire [4:0]  a_b32;
	wire [3:0]  a_b64;
	reg  [23:0] addr_r;
	sfe_addr_split u_split (
		.addr_i       (addr_r),
		.array_addr_o (a_arr),
		.page_byte_o  (a_pb),
		.page_o       (a_pg),
		.sector_o     (a_sec),
		.block32_o    (a_b32),
		.block64_o    (a_b64)
	);
//==============================================================
// frame sequencer
	localparam ST_CMD  = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_DUMY = 3'h2;
	localparam ST_OUT  = 3'h3;
	localparam ST_DATA = 3'h4;
	reg [2:0] st_r;
	reg [2:0] bit_r;
	reg [1:0] byte_r;
	reg [7:0] sh_r;
	reg [7:0] out_r;
	reg       dual_r;
	reg       first_r;
	wire [7:0] sh_nxt = {sh_r[6:0], sin};
	wire last_bit = (bit_r == `SFE_BIT_LAST);
	wire dual_last = (bit_r == `SFE_BIT_LAST - 3'h1);
	// 03 goes straight to data, the other two reads carry a dummy byte
	function is_read;
		input [7:0] c;
		is_read = (c == `SFE_CMD_READ) | (c == `SFE_CMD_FAST_READ) |
			(c == `SFE_CMD_DUAL_READ);
	endfunction
	// drop the bits just sent: two in dual mode, one otherwise
	function [7:0] out_shift;
		input [7:0] v;
		input       dual;
		out_shift = dual ? {v[5:0], 2'h0} : {v[6:0], 1'h0};
	endfunction
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_r <= ST_CMD;
			bit_r <= 3'h0;
			byte_r <= 2'h0;
			sh_r <= 8'h00;
			out_r <= 8'h00;
			dual_r <= 1'h0;
			first_r <= 1'h0;
			addr_r <= 24'h000000;
			cmd_o <= 8'h00;
			cmd_vld_o <= 1'h0;
			addr_vld_o <= 1'h0;
			wr_byte_o <= 8'h00;
			wr_vld_o <= 1'h0;
			rd_addr_o <= 20'h00000;
			page_byte_o <= 8'h00;
			page_o <= 12'h000;
			sector_o <= 8'h00;
			block32_o <= 5'h00;
			block64_o <= 4'h0;
			dual_line_zero_o <= 1'h0;
			dual_line_zero_oe_n_o <= 1'h1;
			dual_line_one_o <= 1'h0;
			dual_line_one_oe_n_o <= 1'h1;
			wprot_n_o <= 1'h1;
		end else begin
			cmd_vld_o <= 1'h0;
			addr_vld_o <= 1'h0;
			wr_vld_o <= 1'h0;
			wprot_n_o <= wp_s_r[1];
			// rd_data_i is read only at a fall, long after this settles
			rd_addr_o <= a_arr;
			page_byte_o <= a_pb;
			page_o <= a_pg;
			sector_o <= a_sec;
			block32_o <= a_b32;
			block64_o <= a_b64;
			if (!selected) begin
				// end of frame releases both lines; a partial byte is
				// dropped, nothing is taken before the eighth rise
				st_r <= ST_CMD;
				first_r <= 1'h0;
				bit_r <= 3'h0;
				byte_r <= 2'h0;
				dual_r <= 1'h0;
				dual_line_zero_oe_n_o <= 1'h1;
				dual_line_one_oe_n_o <= 1'h1;
			end else if (rise) begin
				sh_r <= sh_nxt;
				bit_r <= bit_r + 3'h1;
				case (st_r)
				ST_CMD: if (last_bit) begin
					cmd_o <= sh_nxt;
					cmd_vld_o <= 1'h1;
					dual_r <= (sh_nxt == `SFE_CMD_DUAL_READ);
					byte_r <= 2'h0;
					st_r <= ST_ADDR;
				end
				ST_ADDR: if (last_bit) begin
					addr_r <= {addr_r[15:0], sh_nxt};
					byte_r <= byte_r + 2'h1;
					if (byte_r == `SFE_ADDR_BYTES - 2'h1) begin
						addr_vld_o <= 1'h1;
						first_r <= 1'h1;
						byte_r <= 2'h0;
						if (cmd_o == `SFE_CMD_READ)
							st_r <= ST_OUT;
						else if (is_read(cmd_o))
							st_r <= ST_DUMY;
						else
							st_r <= ST_DATA;
					end
				end
				// the dummy byte is single line even for the dual read
				ST_DUMY: if (last_bit) begin
					st_r <= ST_OUT;
				end
				ST_OUT: begin
					// dual mode takes two bits a clock, four clocks a byte
					if (dual_r) begin
						bit_r <= bit_r + 3'h2;
						if (dual_last)
							addr_r <= addr_r + 24'h1;
					end else if (last_bit)
						addr_r <= addr_r + 24'h1;
				end
				// any byte after the address of a non-read is handed on
				ST_DATA: if (last_bit) begin
					wr_byte_o <= sh_nxt;
					wr_vld_o <= 1'h1;
				end
				default: st_r <= ST_CMD;
				endcase
			end else if (fall && st_r == ST_OUT) begin
				// load the byte at bit 0, then shift msb first
				if (bit_r == 3'h0) begin
					out_r <= out_shift(rd_data_i, dual_r);
					if (dual_r) begin
						dual_line_one_o <= rd_data_i[7];
						dual_line_zero_o <= rd_data_i[6];
					end else
						dual_line_one_o <= rd_data_i[7];
				end else if (dual_r) begin
					out_r <= out_shift(out_r, 1'h1);
					dual_line_one_o <= out_r[7];
					dual_line_zero_o <= out_r[6];
				end else begin
					out_r <= out_shift(out_r, 1'h0);
					dual_line_one_o <= out_r[7];
				end
				// line one, and line zero in dual mode, turn round once per read frame, at the first fall
				if (first_r) begin
					first_r <= 1'h0;
					dual_line_one_oe_n_o <= 1'h0;
					dual_line_zero_oe_n_o <= ~dual_r;
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/sfe_checker.sv
// port assertions for the serial flash front end
`timescale 1ns/10ps
`default_nettype none
module sfe_checker (
	input wire        sys_clk_i,             // clock
	input wire        reset_n_i,             // reset
	input wire        sclk_i,                // pin
	input wire        sel_n_i,               // pin
	input wire        wprot_n_i,             // pin
	input wire        wprot_n_o,             // synced
	input wire        dual_line_zero_oe_n_o, // enable
	input wire        dual_line_one_o,       // data
	input wire        dual_line_one_oe_n_o,  // enable
	input wire        cmd_vld_o,             // pulse
	input wire        addr_vld_o,            // pulse
	input wire [7:0]  cmd_o,                 // command
	input wire [11:0] page_o,                // page
	input wire [7:0]  sector_o,              // sector
	input wire [3:0]  block64_o              // block
);
	//==========
	// properties
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_idle;
		dual_line_zero_oe_n_o && dual_line_one_oe_n_o;
	endsequence
	a_sel_release: assert property ($rose(sel_n_i) |-> ##[1:4] s_idle)
		else $error("lines still driven after deselect");
	a_desel_quiet: assert property (sel_n_i [*4] |-> s_idle)
		else $error("lines driven while deselected");
	a_zero_dual: assert property (!dual_line_zero_oe_n_o |-> cmd_o == 8'h3B)
		else $error("line zero driven outside dual read");
	a_dual_pair: assert property (!dual_line_zero_oe_n_o |-> !dual_line_one_oe_n_o)
		else $error("dual read uses one line only");
	// sclk is a raw pin, so low now and two cycles back means after a fall
	a_out_fall: assert property ($changed(dual_line_one_o) && !dual_line_one_oe_n_o
		|-> !sclk_i && !$past(sclk_i, 2))
		else $error("output changed away from falling edge");
	a_cmd_late: assert property (cmd_vld_o |-> !sel_n_i && !$past(sel_n_i, 200))
		else $error("command too early in frame");
	a_addr_pulse: assert property (addr_vld_o |-> !cmd_vld_o && !sel_n_i ##1 !addr_vld_o)
		else $error("address pulse malformed");
	a_wprot_follow: assert property ($stable(wprot_n_i) [*5] |-> wprot_n_o == wprot_n_i)
		else $error("write protect not followed");
	a_sect_page: assert property (sector_o == page_o[11:4])
		else $error("sector and page disagree");
	a_block_sect: assert property (block64_o == sector_o[7:4])
		else $error("block and sector disagree");
endmodule
bind sfe_front_end sfe_checker u_chk (.sys_clk_i, .reset_n_i, .sclk_i, .sel_n_i,
	.wprot_n_i, .wprot_n_o, .dual_line_zero_oe_n_o, .dual_line_one_o,
	.dual_line_one_oe_n_o, .cmd_vld_o, .addr_vld_o, .cmd_o, .page_o, .sector_o,
	.block64_o);
`default_nettype wire

//--- tb/sfe_host.sv
// host spi controller model driving the flash front end
`timescale 1ns/10ps
`default_nettype none
module sfe_host (
	input  wire  sys_clk_i,   // clock
	input  wire  line_zero_i, // resolved line zero
	input  wire  line_one_i,  // resolved line one
	output logic sclk_o,      // serial clock
	output logic sel_n_o,     // select, active low
	output logic mosi_o,      // host bit
	output logic drv_o        // host drives line zero
);
	logic idle_r;
	initial begin
		sclk_o = 1'b0;
		sel_n_o = 1'b1;
		mosi_o = 1'b0;
		drv_o = 1'b1;
		idle_r = 1'b0;
	end
	//==========
	// frames, clock idles low or high per mode
	task frame(input logic m3);
		@(posedge sys_clk_i) sclk_o <= m3;
		idle_r = m3;
		repeat (20) @(posedge sys_clk_i);
		sel_n_o <= 1'b0;
		repeat (20) @(posedge sys_clk_i);
	endtask
	task stop;
		@(posedge sys_clk_i) sclk_o <= idle_r;
		repeat (20) @(posedge sys_clk_i);
		sel_n_o <= 1'b1;
		drv_o <= 1'b1;
		repeat (40) @(posedge sys_clk_i);
	endtask
	// bit set while clock low, read back at the rise
	task xbyte(input logic [7:0] b, input logic dual, output logic [7:0] r);
		int i;
		for (i = 0; i < 8; i += dual ? 2 : 1) begin
			@(posedge sys_clk_i) sclk_o <= 1'b0;
			mosi_o <= b[7-i];
			drv_o <= !dual;
			repeat (20) @(posedge sys_clk_i);
			sclk_o <= 1'b1;
			r = dual ? {r[5:0], line_one_i, line_zero_i} : {r[6:0], line_one_i};
			repeat (19) @(posedge sys_clk_i);
		end
	endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
// self-checking bench of the flash front end
`timescale 1ns/10ps
`default_nettype none
`include "sfe_map.vh"
module tb;
	logic sys_clk_i = 0, reset_n_i = 0, wprot_n_i = 1, tgl = 0;
	wire sclk_i, sel_n_i, mosi, drv, dual_line_zero_i, dual_line_one_i, wprot_n_o;
	wire dual_line_zero_o, dual_line_zero_oe_n_o, dual_line_one_o;
	wire dual_line_one_oe_n_o, cmd_vld_o, addr_vld_o, wr_vld_o;
	wire [7:0] rd_data_i, cmd_o, page_byte_o, sector_o, wr_byte_o;
	wire [11:0] page_o;
	wire [4:0] block32_o;
	wire [3:0] block64_o;
	wire [19:0] rd_addr_o;
	int n_mismatch = 0, n_compared = 0, seed = 32'h41db, i;
	int n_cmd = 0, n_addr = 0, n_wr = 0, n_frm = 0, n_wr_exp = 0;
	logic [7:0] cmds [4] = '{8'h03, 8'h0B, 8'h3B, 8'h02};
	logic [23:0] a;
	// released lines toggle so a stale level never reads as data
	assign dual_line_zero_i = !dual_line_zero_oe_n_o ? dual_line_zero_o : drv ? mosi : tgl;
	assign dual_line_one_i = !dual_line_one_oe_n_o ? dual_line_one_o : tgl;
	assign rd_data_i = rd_addr_o[7:0] ^ rd_addr_o[19:12];
	sfe_front_end dut (.sys_clk_i, .reset_n_i, .sclk_i, .sel_n_i, .dual_line_zero_i,
		.dual_line_one_i, .wprot_n_i, .rd_data_i, .dual_line_zero_o,
		.dual_line_zero_oe_n_o, .dual_line_one_o, .dual_line_one_oe_n_o, .cmd_o,
		.cmd_vld_o, .rd_addr_o, .page_byte_o, .page_o, .sector_o, .block32_o,
		.block64_o, .addr_vld_o, .wr_byte_o, .wr_vld_o, .wprot_n_o);
	sfe_host u_host (.sys_clk_i, .line_zero_i(dual_line_zero_i),
		.line_one_i(dual_line_one_i), .sclk_o(sclk_i), .sel_n_o(sel_n_i),
		.mosi_o(mosi), .drv_o(drv));
	initial forever #2 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) tgl <= ~tgl;
	// pulses are counted while they stand, one cycle each
	always @(posedge sys_clk_i) begin
		if (cmd_vld_o === 1'b1) n_cmd++;
		if (addr_vld_o === 1'b1) n_addr++;
		if (wr_vld_o === 1'b1) n_wr++;
	end
	//==========
	// helpers
	function logic [7:0] mem(input logic [19:0] x);
		mem = x[7:0] ^ x[19:12];
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task frm(input logic [7:0] c, input logic [23:0] ad, input logic [7:0] d, input logic m3);
		logic [7:0] r;
		logic [19:0] e;
		int k;
		e = ad[19:0];
		n_frm++;
		if (c == 8'h02) n_wr_exp++;
		u_host.frame(m3);
		u_host.xbyte(c, 1'b0, r);
		for (k = 16; k >= 0; k -= 8) u_host.xbyte(ad[k+:8], 1'b0, r);
		chk(cmd_o, c);
		chk(rd_addr_o, e);
		chk(page_byte_o, e[7:0]);
		chk(page_o, e[19:8]);
		chk(block32_o, e[19:15]);
		chk(sector_o, e[19:12]);
		chk(block64_o, e[19:16]);
		if (c == 8'h02) begin
			u_host.xbyte(d, 1'b0, r);
			chk(wr_byte_o, d);
		end else begin
			if (c != `SFE_CMD_READ) u_host.xbyte(8'hA5, 1'b0, r);
			for (k = 0; k < 2; k++) begin
				u_host.xbyte(8'h00, c == `SFE_CMD_DUAL_READ, r);
				chk(r, mem(e + k));
			end
		end
		u_host.stop;
	endtask
	task results;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	//==========
	// main sequence and watchdog
	initial begin
		repeat (4) @(posedge sys_clk_i);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		frm(`SFE_CMD_READ, 24'hFFFFFF, 8'h00, 1'b0);
		frm(`SFE_CMD_DUAL_READ, 24'h0FF0FF, 8'h00, 1'b1);
		for (i = 0; i < 12; i++) begin
			a = $random(seed);
			wprot_n_i <= a[23];
			frm(cmds[i%4], a, $random(seed), i[2]);
			chk(wprot_n_o, a[23]);
		end
		// mid-run reset between frames, then one more frame
		reset_n_i <= 1'b0;
		@(posedge sys_clk_i);
		chk(cmd_o, 8'h00);
		chk(rd_addr_o, 20'h00000);
		chk(dual_line_one_oe_n_o, 1'b1);
		chk(wprot_n_o, 1'b1);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		frm(`SFE_CMD_FAST_READ, 24'h0ABCDE, 8'h00, 1'b0);
		chk(n_cmd, n_frm);
		chk(n_addr, n_frm);
		chk(n_wr, n_wr_exp);
		results;
	end
	initial begin
		repeat (60000) @(posedge sys_clk_i);
		n_mismatch++;
		results;
	end
endmodule
`default_nettype wire
